// File: verilog/rtxks_map.vh
// Constants for the transmitter enable and keying sequencer.
// Included by the sequencer top module only; definitions only.
`ifndef RTXKS_MAP_VH
`define RTXKS_MAP_VH

// Core clock rate in kHz (250 MHz)
`define RTXKS_CLK_KHZ 250000
// Oscillator start plus PLL lock budget, microseconds
`define RTXKS_LOCK_TIME_US 1000
// Lock budget in core clock cycles (longest time, rounds down)
`define RTXKS_LOCK_CYCLES ((`RTXKS_LOCK_TIME_US * `RTXKS_CLK_KHZ) / 1000)
// Clock output is the crystal divided by this
`define RTXKS_CLK_DIV 4
// Half of the divider, in crystal rising edges
`define RTXKS_CLK_HALF 2
// VCO multiplication of the crystal frequency
`define RTXKS_VCO_MULT 64
// Crystal edges that must be seen before lock is declared
`define RTXKS_CRYSTAL_PIN_MIN_EDGES 16
// Sequencer states
`define RTXKS_ST_STANDBY 2'h0
`define RTXKS_ST_START 2'h1
`define RTXKS_ST_READY 2'h2
`define RTXKS_ST_AMP 2'h3

`endif

// File: verilog/rtxks_sync.v
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level or a clock far below clk_i.
`timescale 1ns/1ps
`default_nettype none

module rtxks_sync #(
    parameter WIDTH = 3
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta_r;

// First stage feeds only the second stage
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        meta_r <= {WIDTH{1'b0}};
        sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= async_i;
        sync_o <= meta_r;
    end
end

endmodule // rtxks_sync

`default_nettype wire

// File: verilog/rtxks_top.v
// Enable and keying sequencer of a crystal-referenced UHF transmitter.
// Assumes chip_enable_i, power_amp_on_i and crystal_pin_i are asynchronous pins,
// and that the crystal runs well below a quarter of clk_i.
//
// How it works
// - Both enables low: everything off, standby
// - Enable high starts oscillator, PLL, clock driver
// - Both high: oscillator, PLL, driver, amplifier on
// - Amplifier follows power_amp_on for ASK keying
// - Clock output is crystal divided by four once locked
// - VCO runs at sixty-four times crystal
// - Lock no sooner than 1 ms after enable rise, and only after 16 crystal rises
// - FSK capacitor switch closed lowers output frequency
`timescale 1ns/1ps
`default_nettype none
`include "rtxks_map.vh"

module rtxks_top #(
    parameter LOCK_CYCLES = `RTXKS_LOCK_CYCLES,
    parameter PERIOD_W = 16
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire chip_enable_i,
    input wire power_amp_on_i,
    input wire crystal_pin_i,
    output reg osc_run_o,
    output reg pll_run_o,
    output reg clk_drv_on_o,
    output reg amp_on_o,
    output reg pll_locked_o,
    output reg clk_out_o,
    output reg [PERIOD_W-1:0] crystal_pin_period_o,
    output reg [PERIOD_W+5:0] vco_div_o,
    output reg [1:0] state_o
);

localparam [1:0] ST_STANDBY = `RTXKS_ST_STANDBY;
localparam [1:0] ST_START = `RTXKS_ST_START;
localparam [1:0] ST_READY = `RTXKS_ST_READY;
localparam [1:0] ST_AMP = `RTXKS_ST_AMP;
localparam [1:0] HALF_EDGES = `RTXKS_CLK_HALF;
localparam [4:0] MIN_EDGES = `RTXKS_CRYSTAL_PIN_MIN_EDGES;
localparam [31:0] LOCK_LAST = LOCK_CYCLES - 1;

// Lock is reported in the two running states
function locked_state;
    input [1:0] st;
    begin
        locked_state = (st == ST_READY) || (st == ST_AMP);
    end
endfunction

wire [2:0] pins_s;
wire en_s;
wire amp_s;
wire crystal_pin_s;
reg crystal_pin_d_r;
wire crystal_pin_rise;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [31:0] lock_cnt_r;
reg [4:0] edge_cnt_r;
reg [1:0] div_cnt_r;
reg [PERIOD_W-1:0] period_cnt_r;

// Pins pass two flip-flops before any logic
rtxks_sync #(
    .WIDTH(3)
) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({crystal_pin_i, power_amp_on_i, chip_enable_i}),
    .sync_o(pins_s)
);

assign en_s = pins_s[0];
assign amp_s = pins_s[1];
assign crystal_pin_s = pins_s[2];
assign crystal_pin_rise = crystal_pin_s & ~crystal_pin_d_r;

// Crystal edge detector on the synchronised level
always @(posedge clk_i)
begin
    if (!rst_n_i)
        crystal_pin_d_r <= 1'b0;
    else
        crystal_pin_d_r <= crystal_pin_s;
end

// Next state from enable, lock and amplifier pin
always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_STANDBY:
        begin
            if (en_s)
                state_nxt = ST_START;
        end
        ST_START:
        begin
            if (!en_s)
                state_nxt = ST_STANDBY;
            else if (lock_cnt_r >= LOCK_LAST && edge_cnt_r == MIN_EDGES)
                state_nxt = amp_s ? ST_AMP : ST_READY;
        end
        ST_READY:
        begin
            if (!en_s)
                state_nxt = ST_STANDBY;
            else if (amp_s)
                state_nxt = ST_AMP;
        end
        ST_AMP:
        begin
            if (!en_s)
                state_nxt = ST_STANDBY;
            else if (!amp_s)
                state_nxt = ST_READY;
        end
        default:
            state_nxt = ST_STANDBY;
    endcase
end

// State register, lock timer and crystal edge count
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        state_r <= ST_STANDBY;
        lock_cnt_r <= 32'h0;
        edge_cnt_r <= 5'h0;
    end
    else
    begin
        state_r <= state_nxt;
        if (state_r != ST_START)
        begin
            lock_cnt_r <= 32'h0;
            edge_cnt_r <= 5'h0;
        end
        else
        begin
            if (lock_cnt_r < LOCK_LAST)
                lock_cnt_r <= lock_cnt_r + 32'h1;
            if (crystal_pin_rise && edge_cnt_r != MIN_EDGES)
                edge_cnt_r <= edge_cnt_r + 5'h1;
        end
    end
end

// Enables of the analog parts follow the pins
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        osc_run_o <= 1'b0;
        pll_run_o <= 1'b0;
        clk_drv_on_o <= 1'b0;
        amp_on_o <= 1'b0;
        pll_locked_o <= 1'b0;
        state_o <= ST_STANDBY;
    end
    else
    begin
        osc_run_o <= en_s;
        pll_run_o <= en_s;
        clk_drv_on_o <= en_s;
        amp_on_o <= en_s & amp_s;
        pll_locked_o <= locked_state(state_nxt);
        state_o <= state_nxt;
    end
end

// Clock output toggles every second crystal rise once locked
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        div_cnt_r <= 2'h0;
        clk_out_o <= 1'b0;
    end
    else if (locked_state(state_r))
    begin
        if (crystal_pin_rise)
        begin
            if (div_cnt_r == HALF_EDGES - 2'h1)
            begin
                div_cnt_r <= 2'h0;
                clk_out_o <= ~clk_out_o;
            end
            else
                div_cnt_r <= div_cnt_r + 2'h1;
        end
    end
    else
    begin
        div_cnt_r <= 2'h0;
        clk_out_o <= 1'b0;
    end
end

// Crystal period in core cycles; VCO divide word is 64x that period count
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        period_cnt_r <= {PERIOD_W{1'b0}};
        crystal_pin_period_o <= {PERIOD_W{1'b0}};
        vco_div_o <= {(PERIOD_W+6){1'b0}};
    end
    else if (!en_s)
    begin
        period_cnt_r <= {PERIOD_W{1'b0}};
        crystal_pin_period_o <= {PERIOD_W{1'b0}};
        vco_div_o <= {(PERIOD_W+6){1'b0}};
    end
    else if (crystal_pin_rise)
    begin
        period_cnt_r <= {{(PERIOD_W-1){1'b0}}, 1'b1};
        crystal_pin_period_o <= period_cnt_r;
        // VCO period in units of clk/4096: pulling the crystal lowers output frequency
        vco_div_o <= {period_cnt_r, 6'h00};
    end
    else if (period_cnt_r != {PERIOD_W{1'b1}})
        period_cnt_r <= period_cnt_r + {{(PERIOD_W-1){1'b0}}, 1'b1};
end

endmodule // rtxks_top

`default_nettype wire

// File: tb/rtxks_top_sva.sv
// Port checker for the enable and keying sequencer.
// Bound to rtxks_top from the bench top file; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module rtxks_top_sva #(
    parameter LOCK_CYCLES = 64,
    parameter PERIOD_W = 16
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire chip_enable_i,
    input wire power_amp_on_i,
    input wire crystal_pin_i,
    input wire osc_run_o,
    input wire pll_run_o,
    input wire clk_drv_on_o,
    input wire amp_on_o,
    input wire pll_locked_o,
    input wire clk_out_o,
    input wire [PERIOD_W-1:0] crystal_pin_period_o,
    input wire [PERIOD_W+5:0] vco_div_o,
    input wire [1:0] state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Outputs follow the pins three edges later
    a_standby_off: assert property ($past(rst_n_i, 3) && !$past(chip_enable_i, 3)
        |-> !osc_run_o && !amp_on_o && state_o == 2'h0) else $error("standby not off");
    a_enable_starts: assert property ($past(rst_n_i, 3) |-> osc_run_o == $past(chip_enable_i, 3))
        else $error("oscillator not following enable");
    a_run_together: assert property (pll_run_o == osc_run_o && clk_drv_on_o == osc_run_o)
        else $error("pll or driver apart from oscillator");
    a_amp_keyed: assert property ($past(rst_n_i, 3)
        |-> amp_on_o == ($past(chip_enable_i, 3) && $past(power_amp_on_i, 3))) else $error("amp not keyed");
    // Clock output holds at least 8 cycles after each toggle while locked, unless the oscillator is off
    a_clk_quarter: assert property (pll_locked_o && $changed(clk_out_o) |=> (!osc_run_o || $stable(clk_out_o)) [*8])
        else $error("clock out too fast");
    a_vco_times64: assert property (vco_div_o == {crystal_pin_period_o, 6'h00}) else $error("vco ratio wrong");
    a_lock_window: assert property ($rose(osc_run_o) |-> !pll_locked_o [*8] ##[1:400] pll_locked_o)
        else $error("lock late or early");
    a_locked_state: assert property (pll_locked_o |-> state_o[1] && osc_run_o) else $error("lock state wrong");
    // Main scenarios reached
    c_lock: cover property ($rose(pll_locked_o));
    c_amp: cover property ($rose(amp_on_o));
    c_off: cover property ($fell(osc_run_o));
endmodule // rtxks_top_sva
`default_nettype wire

// File: tb/rtxks_ctrl.sv
// Controller model: drives enable and keying, makes the crystal square wave.
// Assumes clk_i stands in for its own clock; clk_dev_i is the device's divided clock;
// fsk_i closes the pulling switch.
`timescale 1ns/1ps
`default_nettype none
module rtxks_ctrl #(
    parameter WAIT = 300,
    parameter BIT = 2
) (
    input wire logic clk_i,
    input wire logic clk_dev_i,
    input wire logic go_i,
    input wire logic key_i,
    input wire logic fsk_i,
    output var logic chip_enable_o,
    output var logic power_amp_on_o,
    output var logic crystal_o
);
    int cnt_r;
    int bit_r;
    logic dev_d;
    initial
    begin
        chip_enable_o = 1'b0;
        power_amp_on_o = 1'b0;
        crystal_o = 1'b0;
        cnt_r = 0;
        bit_r = 0;
        dev_d = 1'b0;
    end
    // Amp drops first, enable one edge later; amp held off during the wait
    // After the wait keying moves only on device clock rises, one bit per BIT of them
    always @(posedge clk_i)
    begin
        chip_enable_o <= go_i || power_amp_on_o;
        cnt_r <= chip_enable_o ? cnt_r + 1 : 0;
        dev_d <= clk_dev_i;
        if (clk_dev_i && !dev_d)
            bit_r <= (bit_r + 1) % BIT;
        if (!go_i || cnt_r < WAIT)
            power_amp_on_o <= 1'b0;
        else if (clk_dev_i && !dev_d && bit_r == 0)
            power_amp_on_o <= key_i;
    end
    // Crystal still when disabled; switch pulls the period only while transmitting
    always
    begin
        #((fsk_i && power_amp_on_o) ? 28 : 24);
        crystal_o = chip_enable_o & ~crystal_o;
    end
endmodule // rtxks_ctrl
`default_nettype wire

// File: tb/rtxks_top_test.sv
// Bench for the sequencer: controller model in front, table of modes.
// Assumes LOCK_CYCLES of 64 and a 48 ns crystal.
`timescale 1ns/1ps
`default_nettype none
module rtxks_top_test;
    logic clk_i = 0, rst_n_i = 0, go = 0, key = 0, fsk = 0, p;
    wire ce, pa, xt, osc, pll, drv, amp, lck, ck;
    wire [15:0] per;
    wire [21:0] vco;
    wire [1:0] st;
    int miscompares = 0, comparisons = 0, n;
    logic [2:0] stim[4] = '{3'h4, 3'h6, 3'h7, 3'h0};
    logic [19:0] expv[4] = '{20'ha000c, 20'hf000c, 20'hf000e, 20'h00000};
    initial forever #2 clk_i = ~clk_i;
    rtxks_ctrl #(.WAIT(300), .BIT(2)) ctl (.clk_i(clk_i), .clk_dev_i(ck), .go_i(go), .key_i(key), .fsk_i(fsk),
        .chip_enable_o(ce), .power_amp_on_o(pa), .crystal_o(xt));
    rtxks_top #(.LOCK_CYCLES(64)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_enable_i(ce),
        .power_amp_on_i(pa), .crystal_pin_i(xt), .osc_run_o(osc), .pll_run_o(pll),
        .clk_drv_on_o(drv), .amp_on_o(amp), .pll_locked_o(lck), .clk_out_o(ck),
        .crystal_pin_period_o(per), .vco_div_o(vco), .state_o(st));
    // Compare and count
    task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #40000;
        miscompares++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1;
        @(posedge clk_i);
        #1 chk({osc, amp, lck, ck, st, per}, 22'h0);
        chk(vco, 22'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_i);
            {go, key, fsk} <= stim[i];
            repeat (500) @(posedge clk_i);
            #1 chk({osc, amp, st, per}, expv[i]);
            chk({pll, drv}, {2{expv[i][19]}});
            chk(vco, {expv[i][15:0], 6'h00});
            chk(lck, expv[i][17]);
            $display("mode row %0d done", i);
        end
        @(posedge clk_i);
        go <= 1;
        repeat (500) @(posedge clk_i);
        #1 p = ck;
        n = 0;
        // Count toggles over 480 cycles: crystal/4 gives one per 24
        repeat (480)
        begin
            @(posedge clk_i);
            #1 n += (ck !== p);
            p = ck;
        end
        chk(n[21:0], 22'd20);
        $display("clock divide test done");
        // Reset in mid-run while enabled: all outputs clear, then lock again
        @(posedge clk_i);
        rst_n_i <= 0;
        repeat (10) @(posedge clk_i);
        #1 chk({osc, amp, lck, ck, st, per}, 22'h0);
        chk(vco, 22'h0);
        @(posedge clk_i);
        rst_n_i <= 1;
        repeat (2) @(posedge clk_i);
        #1 chk({osc, amp, lck, ck, st, per}, 22'h0);
        repeat (500) @(posedge clk_i);
        #1 chk({osc, amp, st, per}, 20'ha000c);
        chk(lck, 1'b1);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule // rtxks_top_test
bind rtxks_top rtxks_top_sva #(.LOCK_CYCLES(LOCK_CYCLES), .PERIOD_W(PERIOD_W)) sva_i (.clk_i, .rst_n_i,
    .chip_enable_i, .power_amp_on_i, .crystal_pin_i, .osc_run_o, .pll_run_o, .clk_drv_on_o,
    .amp_on_o, .pll_locked_o, .clk_out_o, .crystal_pin_period_o, .vco_div_o, .state_o);
`default_nettype wire
